/* common/lcdpf_pkg.sv */
`default_nettype none
package lcdpf_pkg;
	// register byte offsets
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_HSIZE  = 12'h004;
	localparam logic [11:0] REG_HPORCH = 12'h008;
	localparam logic [11:0] REG_VSIZE  = 12'h00C;
	localparam logic [11:0] REG_VPORCH = 12'h010;
	localparam logic [11:0] REG_CFG    = 12'h014;
	localparam logic [11:0] REG_STAT   = 12'h018;
	localparam logic [1:0]  PAL_PAGE   = 2'h1;

	// reset values
	localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
	localparam logic [31:0] RST_SIZE  = 32'h0000_0000;
	localparam logic [31:0] RST_PORCH = 32'h0000_0000;
	localparam logic [31:0] RST_CFG   = 32'h0000_0000;

	// control word fields
	localparam int CTRL_EN       = 0;
	localparam int CTRL_DEPTH_LO = 1;
	localparam int CTRL_PANEL_LO = 5;
	localparam int CTRL_ACMODE   = 7;
	localparam int CTRL_DIV_LO   = 8;
	localparam int CTRL_LINES_LO = 18;

	// porch word fields, one byte each
	localparam int PORCH_SYNC_LO  = 0;
	localparam int PORCH_BACK_LO  = 8;
	localparam int PORCH_FRONT_LO = 16;

	// format word fields
	localparam int CFG_BSWAP   = 0;
	localparam int CFG_HWSWAP  = 1;
	localparam int CFG_ALIGN   = 2;
	localparam int CFG_F565    = 3;
	localparam int CFG_MVAL_LO = 8;

	// panel mode codes
	localparam logic [1:0] PANEL_DUAL4   = 2'h0;
	localparam logic [1:0] PANEL_SINGLE4 = 2'h1;
	localparam logic [1:0] PANEL_SINGLE8 = 2'h2;
	localparam logic [1:0] PANEL_TFT     = 2'h3;

	// pixel depth codes
	localparam logic [3:0] DEPTH_STN1  = 4'h0;
	localparam logic [3:0] DEPTH_STN2  = 4'h1;
	localparam logic [3:0] DEPTH_STN4  = 4'h2;
	localparam logic [3:0] DEPTH_STN8  = 4'h3;
	localparam logic [3:0] DEPTH_STN12 = 4'h4;
	localparam logic [3:0] DEPTH_TFT1  = 4'h8;
	localparam logic [3:0] DEPTH_TFT2  = 4'h9;
	localparam logic [3:0] DEPTH_TFT4  = 4'hA;
	localparam logic [3:0] DEPTH_TFT8  = 4'hB;
	localparam logic [3:0] DEPTH_TFT16 = 4'hC;
	localparam logic [3:0] DEPTH_TFT24 = 4'hD;

	// timing and packing constants
	localparam logic [9:0] STN_MIN_DIV = 10'h002;
	localparam logic [6:0] PACK_ROOM   = 7'h20;
	localparam logic [6:0] PACK_W24    = 7'h18;
	localparam logic [6:0] PACK_W32    = 7'h20;
	localparam logic [3:0] ACC_ROOM    = 4'h9;
	localparam logic [3:0] COLOUR_BITS = 4'h3;

	typedef enum logic [1:0] {PH_SYNC, PH_BACK, PH_ACT, PH_FRONT} lcdpf_phase_e;
endpackage
`default_nettype wire

/* rtl/lcdpf_bitpack.sv */
`default_nettype none
module lcdpf_bitpack
	import lcdpf_pkg::*;
(
	// clock and clear
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        flush_i,
	// word side
	input  wire logic [31:0] word_i,
	input  wire logic        wide24_i,
	input  wire logic        valid_i,
	output logic             ready_o,
	// bit side
	input  wire logic        take_i,
	input  wire logic [4:0]  nbits_i,
	output logic [23:0]      head_o,
	output logic [6:0]       count_o
);
	logic [63:0] bits;
	logic [6:0]  cnt;
	logic [63:0] next_bits;
	logic [6:0]  next_cnt;

	// a word is only taken while a whole one still fits
	assign ready_o = !flush_i && (cnt <= PACK_ROOM);
	assign head_o  = bits[63:40];
	assign count_o = cnt;

	// bits leave from the top, new words join just below the last valid bit
	always_comb begin
		next_bits = bits;
		next_cnt  = cnt;
		if (take_i) begin
			next_bits = bits << nbits_i;
			next_cnt  = cnt - 7'(nbits_i);
		end
		if (valid_i && ready_o) begin
			next_bits = next_bits | ({word_i, 32'h0000_0000} >> next_cnt); // [RULE5] [RULE21]
			next_cnt  = next_cnt + (wide24_i ? PACK_W24 : PACK_W32);
		end
	end

	// frame start drops whatever is left of the last frame
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			bits <= 64'h0;
			cnt  <= 7'h00;
		end else begin
			bits <= next_bits;
			cnt  <= next_cnt;
		end
	end
endmodule
`default_nettype wire

/* rtl/lcdpf_top.sv */
// How it works
// RULE1 - colour STN sends three bits per pixel, so lines are three times longer
// RULE2 - four-level grey takes two bits per pixel, sixteen-level grey takes four
// RULE3 - 256-colour STN byte: red bits 7-5, green 4-2, blue 1-0
// RULE4 - 4096-colour STN unpacks 12-bit pixels as nibbles across three words
// RULE5 - without byte swap, STN data starts at bit 31 of first word
// RULE6 - dual scan fetches the lower half from its own buffer, MSB first
// RULE7 - STN data goes on the eight-bit bus, clocked in by shift clock
// RULE8 - line pulse follows the last data of each line
// RULE9 - AC bias toggles each frame or after programmed line pulse count
// RULE10 - TFT timing makes vsync, hsync, pixel clock, data enable, line end
// RULE11 - vsync is asserted at every frame start
// RULE12 - software writes sizes minus one; hardware counts value plus one
// RULE13 - TFT pixel clock is bus clock over two times divider plus one
// RULE14 - line and frame phases each last programmed value plus one
// RULE15 - TFT indexed pixels of 1-8 bits via 256-entry palette; 16/24 direct
// RULE16 - 24-bit pixel from bits 23-0 or 31-8 by alignment control
// RULE17 - 24-bit red on lines 23-16, green 15-8, blue 7-0
// RULE18 - 16-bit first pixel from upper half, or lower with halfword swap
// RULE19 - 16-bit 5:6:5 placement; 5:5:5:I drives intensity as each low bit
// RULE20 - byte swap reverses bytes so first pixel comes from lowest byte
// RULE21 - without swaps, pixels leave each word from the top downward
// RULE22 - panel mode: dual-scan 4, single 4, single 8, or TFT
// RULE23 - depth codes select STN 1-12 bpp and TFT 1-24 bpp
// RULE24 - dual scan feeds four bits upper and four bits lower together
`default_nettype none
module lcdpf_top
	import lcdpf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// upper (or only) half word stream
	input  wire logic [31:0] upper_word_i,
	input  wire logic        upper_valid_i,
	output logic             upper_ready_o,
	// lower half word stream, dual scan only
	input  wire logic [31:0] lower_word_i,
	input  wire logic        lower_valid_i,
	output logic             lower_ready_o,
	// frame marker toward the fetch logic
	output logic             frame_start_o,
	// panel pins
	output logic [23:0]      video_data_bus_o,
	output logic             pixel_shift_clock_o,
	output logic             line_pulse_o,
	output logic             ac_bias_output_o,
	output logic             data_enable_output_o,
	output logic             line_end_output_o,
	output logic             vsync_o,
	output logic             hsync_o
);
	logic [31:0] ctrl;
	logic [31:0] hsize;
	logic [31:0] hporch;
	logic [31:0] vsize;
	logic [31:0] vporch;
	logic [31:0] cfg;
	logic [15:0] pal [256];
	logic        ack;

	function automatic logic [4:0] depth_bits(input logic [3:0] d);
		case (d)
			DEPTH_STN2, DEPTH_TFT2:  return 5'h02; // [RULE2]
			DEPTH_STN4, DEPTH_TFT4:  return 5'h04; // [RULE2]
			DEPTH_STN8, DEPTH_TFT8:  return 5'h08;
			DEPTH_STN12:             return 5'h0C; // [RULE4]
			DEPTH_TFT16:             return 5'h10;
			DEPTH_TFT24:             return 5'h18;
			default:                 return 5'h01;
		endcase
	endfunction

	// swap controls act on the word before any pixel leaves it
	function automatic logic [31:0] shape(input logic [31:0] w, input logic bs,
		input logic hs, input logic is24, input logic al);
		logic [31:0] r;
		r = w;
		if (hs) begin
			r = {w[15:0], w[31:16]}; // [RULE18]
		end else if (bs) begin
			r = {w[7:0], w[15:8], w[23:16], w[31:24]}; // [RULE20]
		end
		if (is24) begin
			r = al ? {w[31:8], 8'h00} : {w[23:0], 8'h00}; // [RULE16]
		end
		return r;
	endfunction

	// one pixel to STN output bits; grey keeps its top bit until FRC is added
	function automatic logic [2:0] stn_out(input logic [11:0] h, input logic [3:0] d);
		case (d)
			DEPTH_STN8:  return {h[11], h[8], h[5]}; // [RULE3]
			DEPTH_STN12: return {h[11], h[7], h[3]}; // [RULE4]
			default:     return {h[11], 2'h0};
		endcase
	endfunction

	// 16-bit word to the 24 video lines, unused lines low
	function automatic logic [23:0] tft16(input logic [15:0] p, input logic f565);
		if (f565) begin
			return {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0}; // [RULE19]
		end
		return {p[15:11], p[0], 2'h0, p[10:6], p[0], 2'h0, p[5:1], p[0], 2'h0}; // [RULE19]
	endfunction

	function automatic logic [10:0] plim(input lcdpf_phase_e ph, input logic [31:0] porch,
		input logic [10:0] act);
		case (ph)
			PH_SYNC: return {3'h0, porch[PORCH_SYNC_LO +: 8]};
			PH_BACK: return {3'h0, porch[PORCH_BACK_LO +: 8]};
			PH_ACT:  return act;
			default: return {3'h0, porch[PORCH_FRONT_LO +: 8]};
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction

	// decoded control fields
	logic       en;
	logic [3:0] depth;
	logic [1:0] panel;
	logic [9:0] div;
	logic       tft;
	logic       dual;
	logic       w8;
	logic       colour;
	logic [4:0] nb;
	logic [3:0] lw;
	assign en     = ctrl[CTRL_EN];
	assign depth  = ctrl[CTRL_DEPTH_LO +: 4]; // [RULE23]
	assign panel  = ctrl[CTRL_PANEL_LO +: 2];
	assign div    = ctrl[CTRL_DIV_LO +: 10];
	assign tft    = (panel == PANEL_TFT); // [RULE22]
	assign dual   = (panel == PANEL_DUAL4); // [RULE22]
	assign w8     = (panel == PANEL_SINGLE8); // [RULE22]
	assign colour = !tft && (depth == DEPTH_STN8 || depth == DEPTH_STN12);
	assign nb     = depth_bits(depth);
	assign lw     = w8 ? 4'h8 : 4'h4; // [RULE24]

	// STN line length in shift clocks, rounded up to a whole bus word
	logic [12:0] line_bits;
	logic [12:0] shifts;
	logic [10:0] hact;
	assign line_bits = 13'(({2'h0, hsize[10:0]} + 13'h1) * (colour ? 13'h3 : 13'h1)); // [RULE1]
	assign shifts    = w8 ? ((line_bits + 13'h7) >> 3) : ((line_bits + 13'h3) >> 2);
	assign hact      = tft ? hsize[10:0] : 11'(shifts - 13'h1); // [RULE12]

	// pixel clock divider; STN needs at least four bus clocks per shift clock
	logic [9:0] dcnt;
	logic [9:0] dterm;
	logic       pclk;
	logic       fall;
	assign dterm = tft ? div : ((div < STN_MIN_DIV) ? STN_MIN_DIV - 10'h1 : div - 10'h1); // [RULE13]
	assign fall  = en && (dcnt == dterm) && pclk;
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			dcnt <= 10'h000;
			pclk <= 1'b0;
		end else if (dcnt == dterm) begin
			dcnt <= 10'h000;
			pclk <= !pclk; // [RULE13] [RULE7]
		end else begin
			dcnt <= dcnt + 10'h1;
		end
	end

	// horizontal and vertical phase counters, both advance on the falling edge
	lcdpf_phase_e hph;
	lcdpf_phase_e vph;
	logic [10:0]  hcnt;
	logic [10:0]  vcnt;
	logic         hend;
	logic         vend;
	logic         line_done;
	logic         new_frame;
	logic         act_next;
	assign hend      = (hcnt == plim(hph, hporch, hact)); // [RULE14]
	assign vend      = (vcnt == plim(vph, vporch, {1'b0, vsize[9:0]})); // [RULE14]
	assign line_done = fall && hend && (hph == PH_FRONT);
	assign new_frame = line_done && vend && (vph == PH_FRONT);
	assign act_next  = (hph == PH_BACK && hend) || (hph == PH_ACT && !hend);

	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			hph  <= PH_SYNC;
			hcnt <= 11'h000;
		end else if (fall) begin
			hph  <= hend ? lcdpf_phase_e'(hph + 2'h1) : hph; // [RULE14]
			hcnt <= hend ? 11'h000 : hcnt + 11'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			vph  <= PH_SYNC;
			vcnt <= 11'h000;
		end else if (line_done) begin
			vph  <= vend ? lcdpf_phase_e'(vph + 2'h1) : vph; // [RULE14] [RULE11]
			vcnt <= vend ? 11'h000 : vcnt + 11'h1;
		end
	end

	// word streams; lower stream only serves dual scan
	logic [23:0] pk_head [2];
	logic [6:0]  pk_cnt  [2];
	logic        take    [2];
	logic        flush;
	logic        is24;
	assign flush = !en || new_frame || frame_start_o; // fetch restarts on the late marker
	assign is24  = tft && (depth == DEPTH_TFT24);

	lcdpf_bitpack u_upper (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (flush),
		.word_i  (shape(upper_word_i, cfg[CFG_BSWAP], cfg[CFG_HWSWAP], is24, cfg[CFG_ALIGN])),
		.wide24_i(is24),
		.valid_i (upper_valid_i),
		.ready_o (upper_ready_o),
		.take_i  (take[0]),
		.nbits_i (nb),
		.head_o  (pk_head[0]),
		.count_o (pk_cnt[0])
	);

	lcdpf_bitpack u_lower (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (flush || !dual),
		.word_i  (shape(lower_word_i, cfg[CFG_BSWAP], cfg[CFG_HWSWAP], 1'b0, 1'b0)),
		.wide24_i(1'b0),
		.valid_i (lower_valid_i),
		.ready_o (lower_ready_o), // [RULE6]
		.take_i  (take[1]),
		.nbits_i (nb),
		.head_o  (pk_head[1]),
		.count_o (pk_cnt[1])
	);

	// STN lanes: pixels become output bits in a small accumulator per half
	logic [11:0] acc       [2];
	logic [3:0]  acnt      [2];
	logic [10:0] pcnt      [2];
	logic [11:0] next_acc  [2];
	logic [3:0]  next_acnt [2];
	logic [10:0] next_pcnt [2];
	logic        fill      [2];
	logic        pop;
	assign pop = fall && act_next && (vph == PH_ACT);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_acc[i]  = acc[i];
			next_acnt[i] = acnt[i];
			next_pcnt[i] = pcnt[i];
			fill[i]      = 1'b0;
			if (!en || tft || hph == PH_SYNC) begin
				next_acc[i]  = 12'h000;
				next_acnt[i] = 4'h0;
				next_pcnt[i] = 11'h000;
			end else begin
				if (pop) begin
					next_acc[i]  = acc[i] << lw; // [RULE7]
					next_acnt[i] = (acnt[i] > lw) ? acnt[i] - lw : 4'h0;
				end
				fill[i] = (i == 0 || dual) && (vph == PH_ACT) && (pcnt[i] <= hsize[10:0])
					&& (pk_cnt[i] >= {2'h0, nb}) && (next_acnt[i] <= ACC_ROOM); // [RULE6]
				if (fill[i]) begin
					next_acc[i]  = next_acc[i]
						| ({stn_out(pk_head[i][23:12], depth), 9'h000} >> next_acnt[i]);
					next_acnt[i] = next_acnt[i] + (colour ? COLOUR_BITS : 4'h1); // [RULE1]
					next_pcnt[i] = pcnt[i] + 11'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc  <= '{2{12'h000}};
			acnt <= '{2{4'h0}};
			pcnt <= '{2{11'h000}};
		end else begin
			acc  <= next_acc;
			acnt <= next_acnt;
			pcnt <= next_pcnt;
		end
	end

	// TFT pixel: one per pixel clock while both counters are active
	logic        tft_take;
	logic [7:0]  idx;
	logic [23:0] tft_pix;
	logic [23:0] stn_bus;
	assign tft_take = tft && pop && (pk_cnt[0] >= {2'h0, nb});
	assign take[0]  = tft ? tft_take : fill[0];
	assign take[1]  = fill[1];
	assign idx      = pk_head[0][23:16] >> (5'h08 - nb); // [RULE21] [RULE15]

	always_comb begin
		if (nb == 5'h18) begin
			tft_pix = pk_head[0]; // [RULE17]
		end else if (nb == 5'h10) begin
			tft_pix = tft16(pk_head[0][23:8], cfg[CFG_F565]); // [RULE18] [RULE19]
		end else begin
			tft_pix = tft16(pal[idx], cfg[CFG_F565]); // [RULE15]
		end
		if (dual) begin
			stn_bus = {16'h0000, acc[0][11:8], acc[1][11:8]}; // [RULE24]
		end else if (w8) begin
			stn_bus = {16'h0000, acc[0][11:4]}; // [RULE7]
		end else begin
			stn_bus = {20'h00000, acc[0][11:8]};
		end
	end

	// data changes on the falling pixel clock edge so the panel samples a stable value
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			video_data_bus_o <= 24'h000000;
		end else if (fall) begin
			if (!pop) begin
				video_data_bus_o <= 24'h000000;
			end else if (tft) begin
				video_data_bus_o <= tft_take ? tft_pix : 24'h000000; // [RULE10]
			end else begin
				video_data_bus_o <= stn_bus; // [RULE7]
			end
		end
	end

	// panel control pins, all held low while the block is disabled
	assign pixel_shift_clock_o  = pclk; // [RULE7] [RULE10]
	assign vsync_o              = en && (vph == PH_SYNC); // [RULE11]
	assign hsync_o              = en && tft && (hph == PH_SYNC); // [RULE10]
	assign line_pulse_o         = en && !tft && (hph == PH_SYNC); // [RULE8]
	assign data_enable_output_o = en && tft && (hph == PH_ACT) && (vph == PH_ACT); // [RULE10]
	assign line_end_output_o    = en && tft && (hph == PH_FRONT) && (hcnt == 11'h000);

	always_ff @(posedge clk_i) begin
		frame_start_o <= !rst_i && new_frame;
	end

	// AC bias: per frame, or after a count of line pulses
	logic [7:0] mcnt;
	logic       ac;
	assign ac_bias_output_o = ac;
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			ac   <= 1'b0;
			mcnt <= 8'h00;
		end else if (!ctrl[CTRL_ACMODE]) begin
			ac <= new_frame ? !ac : ac; // [RULE9]
		end else if (line_done) begin
			ac   <= (mcnt == cfg[CFG_MVAL_LO +: 8]) ? !ac : ac; // [RULE9]
			mcnt <= (mcnt == cfg[CFG_MVAL_LO +: 8]) ? 8'h00 : mcnt + 8'h1;
		end
	end

	// wishbone: one wait state, ack drops in the following cycle
	logic        hit;
	logic        pal_hit;
	logic [10:0] lines_left;
	assign hit        = wb_cyc_i && wb_stb_i && !ack;
	assign pal_hit    = (wb_adr_i[11:10] == PAL_PAGE);
	assign wb_ack_o   = ack;
	assign lines_left = (vph == PH_ACT) ? {1'b0, vsize[9:0]} - vcnt : 11'h000;

	always_ff @(posedge clk_i) begin
		ack <= !rst_i && hit;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl   <= RST_CTRL;
			hsize  <= RST_SIZE;
			hporch <= RST_PORCH;
			vsize  <= RST_SIZE;
			vporch <= RST_PORCH;
			cfg    <= RST_CFG;
		end else if (hit && wb_we_i) begin
			case (wb_adr_i)
				REG_CTRL:   ctrl   <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0003_FFFF;
				REG_HSIZE:  hsize  <= merge(hsize, wb_dat_i, wb_sel_i) & 32'h0000_07FF;
				REG_HPORCH: hporch <= merge(hporch, wb_dat_i, wb_sel_i) & 32'h00FF_FFFF;
				REG_VSIZE:  vsize  <= merge(vsize, wb_dat_i, wb_sel_i) & 32'h0000_03FF;
				REG_VPORCH: vporch <= merge(vporch, wb_dat_i, wb_sel_i) & 32'h00FF_FFFF;
				REG_CFG:    cfg    <= merge(cfg, wb_dat_i, wb_sel_i) & 32'h0000_FF0F;
				default:    ;
			endcase
		end
	end

	// palette has no reset; software loads it before enabling an indexed mode
	always_ff @(posedge clk_i) begin
		if (hit && wb_we_i && pal_hit) begin
			pal[wb_adr_i[9:2]] <= 16'(merge({16'h0000, pal[wb_adr_i[9:2]]}, wb_dat_i,
				wb_sel_i)); // [RULE15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (hit && !wb_we_i) begin
			if (pal_hit) begin
				wb_dat_o <= {16'h0000, pal[wb_adr_i[9:2]]};
			end else begin
				case (wb_adr_i)
					REG_CTRL:   wb_dat_o <= {4'h0, lines_left[9:0], ctrl[17:0]};
					REG_HSIZE:  wb_dat_o <= hsize;
					REG_HPORCH: wb_dat_o <= hporch;
					REG_VSIZE:  wb_dat_o <= vsize;
					REG_VPORCH: wb_dat_o <= vporch;
					REG_CFG:    wb_dat_o <= cfg;
					REG_STAT:   wb_dat_o <= {28'h0000000, vph, hph};
					default:    wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* test/lcdpf_assertions.sv */
`default_nettype none
module lcdpf_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// panel pins
	input wire logic [23:0] video_data_bus_o,
	input wire logic        pixel_shift_clock_o,
	input wire logic        data_enable_output_o,
	input wire logic        line_end_output_o,
	input wire logic        vsync_o,
	input wire logic        hsync_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// one request seen by the slave
	wire logic req = wb_cyc_i && wb_stb_i;

	// bus answers exactly one cycle after taking a request
	ack_once_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	// blanking: no pixels while either sync stands
	den_quiet_a:
	assert property (data_enable_output_o |-> !hsync_o && !vsync_o)
		else $error("data enable during sync");
	line_end_a:
	assert property (line_end_output_o |-> !hsync_o && !data_enable_output_o)
		else $error("line end outside front porch");
	// the panel samples on the rising clock, so changes must land on the fall
	data_edge_a:
	assert property ($changed(video_data_bus_o) && video_data_bus_o != 24'h0
		|-> $fell(pixel_shift_clock_o))
		else $error("video data moved off the falling pixel clock");
	den_edge_a:
	assert property ($rose(data_enable_output_o) |-> $fell(pixel_shift_clock_o))
		else $error("data enable rose off the falling pixel clock");
	sync_edge_a:
	assert property ($rose(hsync_o) |-> !pixel_shift_clock_o)
		else $error("hsync rose while pixel clock high");
	// reset must silence the panel even before the first release
	quiet_reset_a: assert property (disable iff (1'b0)
		rst_i |=> !pixel_shift_clock_o && !vsync_o && !hsync_o && !data_enable_output_o)
		else $error("panel pins active after reset");
endmodule
bind lcdpf_top lcdpf_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.video_data_bus_o, .pixel_shift_clock_o, .data_enable_output_o, .line_end_output_o,
	.vsync_o, .hsync_o);
`default_nettype wire

/* test/lcdpf_panel_model.sv */
`default_nettype none
module lcdpf_panel_model (
	// panel pins as the panel sees them
	input wire logic [23:0] video_data_bus_i,
	input wire logic        pixel_shift_clock_i,
	input wire logic        data_enable_output_i,
	input wire logic        vsync_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] row_q[$];
	logic [23:0] frame_q[$];

	// latch on the rising clock, half a period after the data moved
	always @(posedge pixel_shift_clock_i) begin
		if (data_enable_output_i === 1'b1)
			row_q.push_back(video_data_bus_i);
	end
	// vsync sends the line pointer home; the finished frame is kept
	always @(posedge vsync_i) begin
		frame_q = row_q;
		row_q = {};
	end
endmodule
`default_nettype wire

/* test/test_lcd_pixel_format_and_timing.sv */
`default_nettype none
module test_lcd_pixel_format_and_timing import lcdpf_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, run = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0]  wb_sel_i = 4'h0, flg = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, upper_word_i = 32'h0;
	logic        upper_valid_i = 1'b0, wb_ack_o, upper_ready_o, frame_start_o;
	logic [23:0] video_data_bus_o;
	logic        pixel_shift_clock_o, data_enable_output_o, vsync_o, hsync_o, lp, ac;
	logic [31:0] wd[8];
	logic [15:0] pal[256];
	int          miscompares = 0, n_checks = 0, idx = 0;
	localparam logic [3:0] DEP[10] = '{DEPTH_TFT24, DEPTH_TFT24, DEPTH_TFT16, DEPTH_TFT16,
		DEPTH_TFT16, DEPTH_TFT8, DEPTH_TFT8, DEPTH_TFT4, DEPTH_TFT2, DEPTH_TFT1};
	localparam logic [3:0] FLG[10] = '{4'h8, 4'hC, 4'h8, 4'hA, 4'h0, 4'h8, 4'h9, 4'h8, 4'h8, 4'h8};
	localparam int BPP[10] = '{24, 24, 16, 16, 16, 8, 8, 4, 2, 1};

	lcdpf_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .upper_word_i, .upper_valid_i, .upper_ready_o,
		.lower_word_i(32'h0), .lower_valid_i(1'b0), .lower_ready_o(), .frame_start_o,
		.video_data_bus_o, .pixel_shift_clock_o, .line_pulse_o(lp), .ac_bias_output_o(ac),
		.data_enable_output_o, .line_end_output_o(), .vsync_o, .hsync_o);
	lcdpf_panel_model panel (.video_data_bus_i(video_data_bus_o),
		.pixel_shift_clock_i(pixel_shift_clock_o),
		.data_enable_output_i(data_enable_output_o), .vsync_i(vsync_o));

	always #12.5 clk_i = ~clk_i;
	// fetch stand-in: restarts the buffer walk at each frame start, as a dma would
	always @(posedge clk_i) begin
		if (frame_start_o === 1'b1)
			idx = 0;
		else if (upper_valid_i && upper_ready_o === 1'b1)
			idx = (idx + 1) % 8;
		upper_word_i <= wd[idx];
		upper_valid_i <= run;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// classic cycle: hold everything until ack is sampled, then idle a cycle
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// clocks up to the next rise of hsync (0), vsync (1), pixel clock (2) or line pulse (3)
	task automatic gap(input int s, output int n);
		logic p, c;
		n = 0;
		p = 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			c = s == 0 ? hsync_o : s == 1 ? vsync_o : s == 3 ? lp : pixel_shift_clock_o;
			if (c === 1'b1 && p === 1'b0) break;
			p = c;
		end while (n < 4000);
		if (n >= 4000) miscompares++;
	endtask

	// expected pins for pixel j of the frame; swaps first, then msb-first walk
	function automatic logic [23:0] pix(input int b, input int j);
		logic [31:0] w;
		logic [23:0] v;
		w = wd[b == 24 ? j : j * b / 32];
		if (b == 24) return flg[2] ? w[31:8] : w[23:0];
		if (flg[1]) w = {w[15:0], w[31:16]};
		else if (flg[0]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
		v = 24'(w >> (32 - b - (j * b) % 32)) & ((24'h1 << b) - 24'h1);
		if (b < 16) v = 24'(pal[v[7:0]]);
		return flg[3] ? {v[15:11], 3'h0, v[10:5], 2'h0, v[4:0], 3'h0}
			: {v[15:11], v[0], 2'h0, v[10:6], v[0], 2'h0, v[5:1], v[0], 2'h0};
	endfunction

	// 4x2 active area; unconnected pins are masked out of the compare
	task automatic run_mode(input int m);
		int n, b, t;
		logic [31:0] q;
		logic [23:0] mk;
		b = BPP[m];
		t = 2 * (m % 2 + 1);
		mk = b == 24 ? 24'hFFFFFF : FLG[m][3] ? 24'hF8FCF8 : 24'hFCFCFC;
		run <= 1'b0;
		wb(1'b1, REG_CTRL, 32'h0, q);
		flg = FLG[m];
		foreach (wd[i]) wd[i] = $urandom();
		wb(1'b1, REG_HSIZE, 32'h3, q);
		wb(1'b1, REG_HPORCH, 32'h0001_0100, q);
		wb(1'b1, REG_VSIZE, 32'h1, q);
		wb(1'b1, REG_VPORCH, 32'h0, q);
		wb(1'b1, REG_CFG, {28'h0, flg}, q);
		wb(1'b1, REG_CTRL, {14'h0, 10'(m % 2), 1'b0, PANEL_TFT, DEP[m], 1'b1}, q);
		run <= 1'b1;
		gap(1, n);
		gap(1, n);
		gap(2, n);
		gap(2, n);
		chk("pixel clock period", t, n);
		gap(0, n);
		gap(0, n);
		chk("line period", 9 * t, n);
		gap(1, n);
		gap(1, n);
		chk("frame period", 45 * t, n);
		@(posedge clk_i);
		chk("pixels per frame", 8, panel.frame_q.size());
		for (int j = 0; j < 8; j++)
			chk("pixel", pix(b, j) & mk, panel.frame_q[j] & mk);
	endtask

	initial begin
		logic [31:0] q, r;
		int n;
		void'($urandom(76739));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk("control reset", RST_CTRL, q);
		r = $urandom() & 32'h00FF_FFFF;
		wb(1'b1, REG_HPORCH, r, q);
		wb(1'b0, REG_HPORCH, 32'h0, q);
		chk("porch readback", r, q);
		wb(1'b0, 12'h020, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		for (int i = 0; i < 256; i++) begin
			pal[i] = 16'($urandom());
			wb(1'b1, 12'(32'h400 + 4 * i), {16'h0, pal[i]}, q);
		end
		wb(1'b0, 12'h5FC, 32'h0, q);
		chk("palette readback", {16'h0, pal[127]}, q);
		for (int m = 0; m < 10; m++)
			run_mode(m);
		// colour STN on 8 lines: 4 pixels x 3 bits need 2 shift clocks of active, 4 clocks each
		wb(1'b1, REG_CTRL, 32'h0, q);
		wb(1'b1, REG_CTRL, {14'h0, 10'h2, 1'b0, PANEL_SINGLE8, DEPTH_STN8, 1'b1}, q);
		gap(1, n);
		r = 32'(ac);
		gap(1, n);
		chk("stn frame period", 5 * 4 * (1 + 2 + 2 + 2), n);
		chk("ac bias toggle", r ^ 32'h1, 32'(ac));
		gap(3, n);
		gap(3, n);
		chk("stn line period", 4 * (1 + 2 + 2 + 2), n);
		wrap_up();
	end

	// hang guard, well past the roughly 7000 cycles the run needs
	initial begin
		#(30000 * 25);
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
